// ---- hw/can_irq_pkg.sv ----
package can_irq_pkg;
    // printed register positions are indices; byte address is four times the index
    localparam logic [7:0] enables_index = 8'h04;
    localparam logic [7:0] position_index = 8'h0b;
    localparam logic [7:0] flags_index = 8'h03;
    localparam logic [7:0] enables_addr = 8'h10;
    localparam logic [7:0] position_addr = 8'h2c;
    localparam logic [7:0] flags_addr = 8'h0c;
    // bit positions shared by enables and flags
    localparam int bus_fault_bit = 7;
    localparam int arb_loss_bit = 6;
    localparam int passive_state_bit = 5;
    localparam int wakeup_bit = 4;
    localparam int overrun_bit = 3;
    localparam int warning_bit = 2;
    localparam int tx_done_bit = 1;
    localparam int rx_full_bit = 0;
    localparam int pos_width = 5;
    localparam logic [7:0] enables_reset = 8'h00;
    localparam logic [7:0] flags_reset = 8'h00;
    localparam logic [4:0] position_reset = 5'h00;
endpackage : can_irq_pkg

// ---- hw/can_irq_enable_arb_capture.sv ----
// Contract
// RL1: enable register at index 4, readable and writable, one bit per source.
// RL2: bit 7 set lets a bus error raise its interrupt.
// RL3: bit 6 set lets arbitration loss raise its interrupt.
// RL4: bit 5 set raises interrupt on each active/passive error state change.
// RL5: bit 4 set raises interrupt when the controller leaves sleep.
// RL6: bit 3 set raises interrupt when overrun status rises.
// RL7: bit 2 set raises interrupt on any error or bus status change.
// RL8: bit 1 set raises interrupt on transmit buffer released.
// RL9: bit 0 set requests receive interrupt while receive buffer full.
// RL10: clearing receive enable releases interrupt output high if nothing else pending.
// RL11: capture register at index 11 is read-only, top three bits zero.
// RL12: low five bits hold frame bit position of arbitration loss.
// RL13: on arbitration loss raise interrupt if enabled and capture position.
// RL14: captured value frozen until host reads it once, then re-armed.
// RL15: arbitration lost flag cleared by reading the flag register.
// RL16: no new arbitration lost interrupt before capture register is read.
// RL17: captured value is binary frame bit number 0 to 31.
// RL18: receive flag not cleared by flag read; follows fifo status.
// RL19: sleep attempt with bus activity or pending interrupt raises wake-up.
// RL20: interrupt output low while any enabled flag is pending, else high. Here a sticky flag stays set and holds irq_n low after its enable is cleared.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module can_irq_enable_arb_capture (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_error_evt,
    input wire logic arb_lost_evt,
    input wire logic [4:0] arb_lost_pos,
    input wire logic error_passive,
    input wire logic wakeup_evt,
    input wire logic sleep_request_evt,
    input wire logic bus_active,
    input wire logic overrun_status,
    input wire logic error_status,
    input wire logic bus_status,
    input wire logic tx_buf_released,
    input wire logic rx_fifo_not_empty,
    output logic irq_n
);
    logic [7:0] enables_reg, enables_next;
    logic [7:0] flags_reg, flags_next;
    logic [4:0] position_reg, position_next;
    logic armed_reg, armed_next;
    logic [4:0] prev_reg, prev_next; // passive, overrun, error, bus, tx
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_n_reg, irq_n_next;
    logic setup, access, wr, rd;
    logic [7:0] ev;
    logic arb_take;

    // address decode, used for both answer and side effects
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == can_irq_pkg::enables_addr) || (a == can_irq_pkg::position_addr)
            || (a == can_irq_pkg::flags_addr);
    endfunction : mapped

    // bus phases; read side effects only at the completing edge
    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign wr = access && pwrite && mapped(paddr);
    assign rd = access && !pwrite;
    // capture only while armed, so a second loss cannot overwrite the frozen value
    assign arb_take = arb_lost_evt && armed_reg;

    // source events before enable gating
    always_comb begin
        ev = 8'h00;
        ev[can_irq_pkg::bus_fault_bit] = bus_error_evt;
        ev[can_irq_pkg::arb_loss_bit] = arb_take; // [RL16]
        ev[can_irq_pkg::passive_state_bit] = error_passive != prev_reg[4]; // [RL4]
        ev[can_irq_pkg::wakeup_bit] = wakeup_evt
            || (sleep_request_evt && (bus_active || !irq_n_reg)); // [RL5] [RL19]
        ev[can_irq_pkg::overrun_bit] = overrun_status && !prev_reg[3]; // [RL6]
        ev[can_irq_pkg::warning_bit] = (error_status != prev_reg[2])
            || (bus_status != prev_reg[1]); // [RL7]
        ev[can_irq_pkg::tx_done_bit] = tx_buf_released && !prev_reg[0]; // [RL8]
    end

    // register file, flags, capture and interrupt output
    always_comb begin
        enables_next = enables_reg;
        flags_next = flags_reg;
        position_next = position_reg;
        armed_next = armed_reg;
        prev_next = {error_passive, overrun_status, error_status, bus_status, tx_buf_released};
        if (wr && paddr == can_irq_pkg::enables_addr) begin
            enables_next = pwdata[7:0]; // [RL1]
        end
        // flag read clears sticky flags; a new event in the same cycle wins
        if (rd && paddr == can_irq_pkg::flags_addr) begin
            flags_next = 8'h00; // [RL15]
        end
        flags_next = flags_next | (ev & enables_reg); // [RL2] [RL3] [RL13]
        // receive flag is a level, never sticky
        flags_next[can_irq_pkg::rx_full_bit] = rx_fifo_not_empty
            && enables_next[can_irq_pkg::rx_full_bit]; // [RL9] [RL18]
        if (rd && paddr == can_irq_pkg::position_addr) begin
            armed_next = 1'b1; // [RL14]
        end
        if (arb_take) begin
            position_next = arb_lost_pos; // [RL12] [RL13] [RL17]
            armed_next = 1'b0;
        end
        irq_n_next = ~|flags_next; // [RL10] [RL20]
    end

    // apb answer prepared in setup so outputs come from flops; zero wait states
    always_comb begin
        prdata_next = 32'h0000_0000;
        pready_next = setup;
        pslverr_next = setup && !mapped(paddr);
        if (setup && !pwrite) begin
            case (paddr)
                can_irq_pkg::enables_addr: prdata_next = {24'h00_0000, enables_reg}; // [RL1]
                can_irq_pkg::position_addr: prdata_next = {27'h000_0000, position_reg}; // [RL11]
                can_irq_pkg::flags_addr: prdata_next = {24'h00_0000, flags_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_reg <= can_irq_pkg::enables_reset;
            flags_reg <= can_irq_pkg::flags_reset;
            position_reg <= can_irq_pkg::position_reset;
            armed_reg <= 1'b1;
            prev_reg <= 5'h00;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            enables_reg <= enables_next;
            flags_reg <= flags_next;
            position_reg <= position_next;
            armed_reg <= armed_next;
            prev_reg <= prev_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_n = irq_n_reg;

    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == can_irq_pkg::enables_addr |=> enables_reg == $past(pwdata[7:0]))
        else $error("enable write not stored"); // [RL1]
    a_bus_fault_gate: assert property (@(posedge pclk) disable iff (!presetn)
        bus_error_evt && enables_reg[7] |=> flags_reg[7])
        else $error("bus fault flag missing"); // [RL2]
    a_arb_gate: assert property (@(posedge pclk) disable iff (!presetn)
        arb_lost_evt && armed_reg && !enables_reg[6] && !flags_reg[6] |=> !flags_reg[6])
        else $error("arb flag set while disabled"); // [RL3]
    a_passive_change: assert property (@(posedge pclk) disable iff (!presetn)
        enables_reg[5] && error_passive != $past(error_passive) |=> flags_reg[5])
        else $error("passive change not flagged"); // [RL4]
    a_overrun_rise: assert property (@(posedge pclk) disable iff (!presetn)
        enables_reg[3] && $rose(overrun_status) |=> flags_reg[3])
        else $error("overrun rise not flagged"); // [RL6]
    a_rx_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 flags_reg[0] == $past(rx_fifo_not_empty && enables_next[0]))
        else $error("receive flag not following fifo"); // [RL9]
    a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
        irq_n == ~|flags_reg)
        else $error("interrupt output mismatch"); // [RL20]
    a_capture_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        !armed_reg && !(rd && paddr == can_irq_pkg::position_addr) |=> $stable(position_reg))
        else $error("capture changed while frozen"); // [RL14]
    a_capture_take: assert property (@(posedge pclk) disable iff (!presetn)
        arb_lost_evt && armed_reg |=> position_reg == $past(arb_lost_pos) && !armed_reg)
        else $error("position not captured"); // [RL13]
    a_no_rearm_irq: assert property (@(posedge pclk) disable iff (!presetn)
        !armed_reg ##1 !$past(rd && paddr == can_irq_pkg::position_addr)
        |-> !($rose(flags_reg[6])))
        else $error("arb interrupt before capture read"); // [RL16]
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == can_irq_pkg::flags_addr && !arb_lost_evt |=> !flags_reg[6])
        else $error("arb flag not cleared by read"); // [RL15]
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:5] == 27'h000_0000 || $past(paddr) != can_irq_pkg::position_addr)
        else $error("capture reserved bits nonzero"); // [RL11]

    // wake-up pulse reaches its flag when enabled
    a_wakeup_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        wakeup_evt && enables_reg[4] |=> flags_reg[4])
        else $error("wake-up flag missing");

    // sleep attempt while the bus is busy counts as wake-up
    a_sleep_busy: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
        sleep_request_evt && bus_active && enables_reg[4] |=> flags_reg[4])
        else $error("sleep during activity not flagged");

    // sleep attempt with an interrupt pending counts as wake-up
    a_sleep_pending: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
        sleep_request_evt && !irq_n && enables_reg[4] |=> flags_reg[4])
        else $error("sleep with pending irq not flagged");

    // masked wake-up leaves no trace
    a_wakeup_masked: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        !enables_reg[4] && !flags_reg[4] |=> !flags_reg[4])
        else $error("wake-up flag set while disabled");

    // error status edge feeds the warning flag
    a_error_change: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        enables_reg[2] && error_status != $past(error_status) |=> flags_reg[2])
        else $error("error status change not flagged");

    // bus status edge feeds the warning flag as well
    a_bus_change: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        enables_reg[2] && bus_status != $past(bus_status) |=> flags_reg[2])
        else $error("bus status change not flagged");

    // buffer release edge raises transmit flag
    a_tx_release: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        enables_reg[1] && $rose(tx_buf_released) |=> flags_reg[1])
        else $error("transmit release not flagged");

    // armed loss with enable set raises the flag
    a_arb_enabled: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        arb_lost_evt && armed_reg && enables_reg[6] |=> flags_reg[6])
        else $error("arb flag missing");

    // masked bus error is dropped, not remembered
    a_bus_fault_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        bus_error_evt && !enables_reg[7] && !flags_reg[7] |=> !flags_reg[7])
        else $error("bus fault flag set while disabled");

    // masked passive change is dropped
    a_passive_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        !enables_reg[5] && !flags_reg[5] |=> !flags_reg[5])
        else $error("passive flag set while disabled");

    // masked overrun is dropped
    a_overrun_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        !enables_reg[3] && !flags_reg[3] |=> !flags_reg[3])
        else $error("overrun flag set while disabled");

    // receive flag follows its enable with no lag
    a_rx_masked: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
        !enables_reg[0] |-> !flags_reg[0])
        else $error("receive flag set while disabled");

    // flag read must not drop a full receive buffer
    a_rx_no_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RL18]
        rd && paddr == can_irq_pkg::flags_addr && rx_fifo_not_empty && enables_next[0]
        |=> flags_reg[0])
        else $error("receive flag cleared by read");

    // loss while disarmed must not touch the frozen position
    a_disarmed_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL16]
        arb_lost_evt && !armed_reg |=> $stable(position_reg))
        else $error("capture overwritten while disarmed");

    // position read re-arms the capture
    a_rearm_read: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
        rd && paddr == can_irq_pkg::position_addr && !arb_lost_evt |=> armed_reg)
        else $error("capture not re-armed");

    // host write to the capture register is ignored
    a_position_ro: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        wr && paddr == can_irq_pkg::position_addr && !arb_take |=> $stable(position_reg))
        else $error("capture register written");

    // enable readback returns the stored byte
    a_read_enables: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        setup && !pwrite && paddr == can_irq_pkg::enables_addr
        |=> prdata == {24'h00_0000, $past(enables_reg)})
        else $error("enable readback wrong");

    // position readback returns the captured bits
    a_read_position: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        setup && !pwrite && paddr == can_irq_pkg::position_addr
        |=> prdata == {27'h000_0000, $past(position_reg)})
        else $error("position readback wrong");

    // answer stands one cycle only
    a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held too long");

    // zero wait states: setup always answered next cycle
    a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no answer after setup");

    // unmapped offsets answer with an error
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped(paddr) |=> pslverr)
        else $error("unmapped access without error");
endmodule : can_irq_enable_arb_capture
`default_nettype wire

// ---- dv/can_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// stands in for the protocol engine: one source pulse, position valid with it
module can_core_model (
    input wire logic clk,
    output logic [7:0] src,
    output logic [4:0] pos
);
    initial begin
        src = 8'h00;
        pos = 5'h00;
    end
    // position is scrambled after the pulse so a late sample cannot pass
    task automatic fire(input int b, input logic [4:0] p);
        @(posedge clk);
        src[b] <= 1'b1;
        pos <= p;
        @(posedge clk);
        src[b] <= 1'b0;
        pos <= ~p;
    endtask : fire
endmodule : can_core_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, rx, perr;
    logic slp, busy;
    logic [7:0] paddr, src;
    logic [4:0] pos;
    logic [31:0] pwdata, prdata, rd;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    can_core_model bsp (.clk(pclk), .src(src), .pos(pos));
    can_irq_enable_arb_capture dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_error_evt(src[7]), .arb_lost_evt(src[6]),
        .arb_lost_pos(pos), .error_passive(src[5]), .wakeup_evt(src[4]),
        .sleep_request_evt(slp), .bus_active(busy), .overrun_status(src[3]),
        .error_status(src[2]), .bus_status(1'b0), .tx_buf_released(src[1]),
        .rx_fifo_not_empty(rx), .irq_n(irq_n));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // sample mid-cycle, where the flopped answer has settled
        do @(negedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // error flag folded into bit 31, which no register uses
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk({perr, rd[30:0]}, {e, exp[30:0]});
    endtask : rdc
    task automatic t_regs;
        rdc(can_irq_pkg::enables_addr, 32'h0000_0000, 1'b0);
        rdc(can_irq_pkg::position_addr, 32'h0000_0000, 1'b0);
        apb(1'b1, can_irq_pkg::position_addr, 32'hffff_ffff);
        rdc(can_irq_pkg::position_addr, 32'h0000_0000, 1'b0);
        apb(1'b1, can_irq_pkg::enables_addr, 32'h0000_00a5);
        rdc(can_irq_pkg::enables_addr, 32'h0000_00a5, 1'b0);
        rdc(8'h3c, 32'h0000_0000, 1'b1);
        $display("test regs done");
    endtask : t_regs
    // each source except arbitration loss and receive masked, then enabled; flag and irq_n judged per source
    task automatic t_sources;
        int bits[6] = '{7, 5, 4, 3, 2, 1};
        logic [7:0] en;
        for (int m = 0; m < 2; m++) begin
            en = (m == 0) ? 8'h00 : 8'hff;
            apb(1'b1, can_irq_pkg::enables_addr, {24'h00_0000, en});
            foreach (bits[i]) begin
                bsp.fire(bits[i], 5'h00);
                repeat (2) @(posedge pclk);
                chk({31'h0, irq_n}, {31'h0, ~en[0]});
                rdc(can_irq_pkg::flags_addr, {24'h0, en & (8'h01 << bits[i])}, 1'b0);
            end
        end
        $display("test sources done");
    endtask : t_sources
    task automatic t_arb;
        apb(1'b1, can_irq_pkg::enables_addr, 32'h0000_0040);
        bsp.fire(6, 5'h1f);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_n}, 32'h0000_0000);
        bsp.fire(6, 5'h0a);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0040, 1'b0);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0000, 1'b0);
        rdc(can_irq_pkg::position_addr, 32'h0000_001f, 1'b0);
        bsp.fire(6, 5'h0b);
        repeat (2) @(posedge pclk);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0040, 1'b0);
        rdc(can_irq_pkg::position_addr, 32'h0000_000b, 1'b0);
        $display("test arb done");
    endtask : t_arb
    // sleep attempt during bus activity must still wake the host
    task automatic t_sleep;
        apb(1'b1, can_irq_pkg::enables_addr, 32'h0000_0010);
        slp <= 1'b1;
        busy <= 1'b1;
        @(posedge pclk);
        slp <= 1'b0;
        busy <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0010, 1'b0);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_rx;
        apb(1'b1, can_irq_pkg::enables_addr, 32'h0000_0001);
        rx <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_n}, 32'h0000_0000);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0001, 1'b0);
        rdc(can_irq_pkg::flags_addr, 32'h0000_0001, 1'b0);
        apb(1'b1, can_irq_pkg::enables_addr, 32'h0000_0000);
        @(posedge pclk);
        #1;
        chk({31'h0, irq_n}, 32'h0000_0001);
        rx <= 1'b0;
        $display("test rx done");
    endtask : t_rx
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // hang guard, well above the fewer than two hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, rx} = 5'b0_0000;
        paddr = 8'h00;
        slp = 1'b0;
        busy = 1'b0;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sources();
        t_arb();
        t_sleep();
        t_rx();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
